// *** src/perfsel_pkg.sv ***
// Constants and types shared by the event-select counter block.
// Assumes a 32-bit Avalon-MM register bus and a core clock pipeline.
package perfsel_pkg;

  // Event codes and unit masks of the countable selections.
  localparam logic [7:0] PERFSEL_EV_SEG_RENAME = 8'hD5;
  localparam logic [7:0] PERFSEL_EV_RES_STALL = 8'hDC;
  localparam logic [7:0] PERFSEL_EV_BR_DECODED = 8'hE0;
  localparam logic [7:0] PERFSEL_EV_FALSE_BR = 8'hE4;
  localparam logic [7:0] PERFSEL_EV_RESTEER = 8'hE6;
  localparam logic [7:0] PERFSEL_EV_PREF_UP = 8'hF0;
  localparam logic [7:0] PERFSEL_EV_PREF_DN = 8'hF8;
  localparam logic [7:0] PERFSEL_UM_NONE = 8'h00;
  localparam logic [7:0] PERFSEL_UM_GS = 8'h08;
  localparam logic [7:0] PERFSEL_UM_SEG_ANY = 8'h0F;
  localparam logic [7:0] PERFSEL_UM_RETQ_FULL = 8'h01;
  localparam logic [7:0] PERFSEL_UM_ISSQ_FULL = 8'h02;
  localparam logic [7:0] PERFSEL_UM_LDST = 8'h04;
  localparam logic [7:0] PERFSEL_UM_FPCW = 8'h08;
  localparam logic [7:0] PERFSEL_UM_MISPRED = 8'h10;
  localparam logic [7:0] PERFSEL_UM_STALL_ANY = 8'h1F;

  // Register byte offsets.
  localparam logic [4:0] PERFSEL_OFS_CTRL = 5'h00;
  localparam logic [4:0] PERFSEL_OFS_COUNT = 5'h04;
  localparam logic [4:0] PERFSEL_OFS_STATUS = 5'h08;
  localparam logic [4:0] PERFSEL_OFS_IRQ_CLR = 5'h0C;
  localparam logic [4:0] PERFSEL_OFS_IRQ_EN = 5'h10;

  // Control field positions and reset values.
  localparam int PERFSEL_CTRL_EV_LSB = 0;
  localparam int PERFSEL_CTRL_UM_LSB = 8;
  localparam int PERFSEL_CTRL_EN_BIT = 16;
  localparam logic [31:0] PERFSEL_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PERFSEL_COUNT_RST = 32'h0000_0000;

  // Status bit positions: counter wrap and enabled with an unknown selection.
  localparam int PERFSEL_ST_WRAP = 0;
  localparam int PERFSEL_ST_BADSEL = 1;
  localparam int PERFSEL_ST_W = 2;

  // Span trackers: load limit, store limit, mispredict recovery.
  localparam int PERFSEL_SPAN_LOAD = 0;
  localparam int PERFSEL_SPAN_STORE = 1;
  localparam int PERFSEL_SPAN_RECOV = 2;
  localparam int PERFSEL_SPAN_N = 3;

  // Pipeline condition signals, all synchronous to the core clock.
  typedef struct packed {
    logic [3:0] seg_rename;          // One bit each for ES, DS, FS, GS (bit 3).
    logic retire_queue_full;         // Level.
    logic issue_queue_full;          // Level.
    logic load_limit_hit;            // Pulse: in-flight loads reached the limit.
    logic load_retired;              // Pulse: a load retired.
    logic store_limit_hit;           // Pulse: in-flight stores reached the limit.
    logic store_committed;           // Pulse: a store committed its data.
    logic fence_wait;                // Level: waiting for all earlier stores.
    logic float_cw_stall;            // Level.
    logic mispredict_detect;         // Pulse at execution.
    logic mispredict_drained;        // Pulse: branch and older micro-ops retired.
    logic branch_decoded;            // Pulse.
    logic false_branch;              // Pulse.
    logic frontend_resteer;          // Pulse.
    logic upward_prefetch;           // Pulse.
    logic downward_prefetch;         // Pulse.
  } perfsel_cond_t;

  // Avalon-MM slave request.
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } perfsel_avm_req_t;

endpackage

// *** src/perfsel_span.sv ***
// One stall span tracker: starts on a pulse, holds until an end pulse.
// Assumes start and stop pulses are synchronous to the core clock.
`timescale 1ns/100ps
module perfsel_span (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Span edges.
  input wire logic start,
  input wire logic stop,
  // Span state, including the start cycle itself.
  output logic active
);

  logic held_r;

  // A start in the same cycle as a stop keeps the span open, so no stall is lost.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      held_r <= 1'b0;
    end else if (start) begin
      held_r <= 1'b1;
    end else if (stop) begin
      held_r <= 1'b0;
    end
  end

  // The stop cycle still counts, since the stall lasts until that edge.
  assign active = start | held_r;

endmodule

// *** src/perfsel_top.sv ***
// Performance counter with event selection over pipeline conditions.
// Assumes pipeline condition inputs are synchronous to core_clk and an
// Avalon-MM master that holds each request until waitrequest is low.
//
// Functional notes
// - Code D5H, mask 08H: count each GS segment rename.
// - Code D5H, mask 0FH: count each ES, DS, FS or GS rename.
// - Code DCH, mask 01H: count cycles with the retire queue full.
// - Code DCH, mask 02H: count cycles with the issue queue full.
// - Code DCH, mask 04H: count load-limit stall cycles until a load retires.
// - Same selection counts store-limit stall cycles until a store commits.
// - Same selection counts cycles waiting for all earlier stores to commit.
// - Code DCH, mask 08H: count cycles stalled by float control word writes.
// - Code DCH, mask 10H: count cycles from mispredict until older micro-ops retire.
// - Code DCH, mask 1FH: count cycles with any of the five stalls.
// - Code E0H, mask 00H: count each decoded branch.
// - Code E4H, mask 00H: count bytes wrongly seen as taken branches.
// - Code E6H, mask 00H: count each front-end resteer.
// - Code F0H, mask 00H: count upward prefetch requests to the second cache.
// - Code F8H, mask 00H: count downward prefetch requests to the second cache.
// - An issued prefetch is never cancelled, so issue alone is counted.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module perfsel_top
  import perfsel_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Avalon-MM slave.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pipeline conditions.
  input wire perfsel_cond_t cond,
  // Interrupt.
  output logic irq
);

  perfsel_avm_req_t req;
  logic [31:0] ctrl_r;
  logic [CNT_W-1:0] count_r;
  logic [PERFSEL_ST_W-1:0] status_r;
  logic [PERFSEL_ST_W-1:0] irq_en_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic [7:0] ev_code;
  logic [7:0] umask;
  logic count_en;
  logic [PERFSEL_SPAN_N-1:0] span_start;
  logic [PERFSEL_SPAN_N-1:0] span_stop;
  logic [PERFSEL_SPAN_N-1:0] span_act;
  logic ldst_stall;
  logic any_stall;
  logic [2:0] inc;
  logic sel_known;
  logic [CNT_W:0] count_sum;
  logic acc_now;
  logic wr_ctrl;
  logic wr_count;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic [PERFSEL_ST_W-1:0] st_set;

  // Merge write data into an old word under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Gather the bus request into one carrier.
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};

  // Decode of the programmed selection.
  assign ev_code = ctrl_r[PERFSEL_CTRL_EV_LSB +: 8];
  assign umask = ctrl_r[PERFSEL_CTRL_UM_LSB +: 8];
  assign count_en = ctrl_r[PERFSEL_CTRL_EN_BIT];

  // Span edges for the loads, stores and mispredict recovery trackers.
  assign span_start[PERFSEL_SPAN_LOAD] = cond.load_limit_hit;
  assign span_stop[PERFSEL_SPAN_LOAD] = cond.load_retired;
  assign span_start[PERFSEL_SPAN_STORE] = cond.store_limit_hit;
  assign span_stop[PERFSEL_SPAN_STORE] = cond.store_committed;
  assign span_start[PERFSEL_SPAN_RECOV] = cond.mispredict_detect;
  assign span_stop[PERFSEL_SPAN_RECOV] = cond.mispredict_drained;

  // One tracker per stall span; all three behave alike.
  generate
    for (genvar g = 0; g < PERFSEL_SPAN_N; g++) begin : g_span
      perfsel_span u_span (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(span_start[g]),
        .stop(span_stop[g]),
        .active(span_act[g])
      );
    end
  endgenerate

  // Load/store stall combines both limits and the wait for store commit.
  assign ldst_stall = span_act[PERFSEL_SPAN_LOAD] | span_act[PERFSEL_SPAN_STORE]
                      | cond.fence_wait;

  // Any resource stall is one count per cycle, however many hold at once.
  assign any_stall = cond.retire_queue_full | cond.issue_queue_full | ldst_stall
                     | cond.float_cw_stall | span_act[PERFSEL_SPAN_RECOV];

  // Increment for the current cycle; unknown selections add nothing.
  always_comb begin
    inc = 3'd0;
    sel_known = 1'b1;
    if (ev_code == PERFSEL_EV_SEG_RENAME && umask == PERFSEL_UM_GS) begin
      inc = {2'd0, cond.seg_rename[3]};
    end else if (ev_code == PERFSEL_EV_SEG_RENAME && umask == PERFSEL_UM_SEG_ANY) begin
      inc = 3'(cond.seg_rename[0]) + 3'(cond.seg_rename[1])
            + 3'(cond.seg_rename[2]) + 3'(cond.seg_rename[3]);
    end else if (ev_code == PERFSEL_EV_RES_STALL) begin
      unique case (umask)
        PERFSEL_UM_RETQ_FULL: begin
          inc = {2'd0, cond.retire_queue_full};
        end
        PERFSEL_UM_ISSQ_FULL: begin
          inc = {2'd0, cond.issue_queue_full};
        end
        PERFSEL_UM_LDST: begin
          inc = {2'd0, ldst_stall};
        end
        PERFSEL_UM_FPCW: begin
          inc = {2'd0, cond.float_cw_stall};
        end
        PERFSEL_UM_MISPRED: begin
          inc = {2'd0, span_act[PERFSEL_SPAN_RECOV]};
        end
        PERFSEL_UM_STALL_ANY: begin
          inc = {2'd0, any_stall};
        end
        default: begin
          sel_known = 1'b0;
        end
      endcase
    end else if (umask != PERFSEL_UM_NONE) begin
      sel_known = 1'b0;
    end else if (ev_code == PERFSEL_EV_BR_DECODED) begin
      inc = {2'd0, cond.branch_decoded};
    end else if (ev_code == PERFSEL_EV_FALSE_BR) begin
      inc = {2'd0, cond.false_branch};
    end else if (ev_code == PERFSEL_EV_RESTEER) begin
      inc = {2'd0, cond.frontend_resteer};
    end else if (ev_code == PERFSEL_EV_PREF_UP) begin
      inc = {2'd0, cond.upward_prefetch};
    end else if (ev_code == PERFSEL_EV_PREF_DN) begin
      inc = {2'd0, cond.downward_prefetch};
    end else begin
      sel_known = 1'b0;
    end
  end

  // Bus access strobes: an access takes effect when waitrequest is low.
  assign acc_now = (req.read | req.write) & ~wait_r;
  assign wr_ctrl = acc_now & req.write & (req.address == PERFSEL_OFS_CTRL);
  assign wr_count = acc_now & req.write & (req.address == PERFSEL_OFS_COUNT);
  assign wr_irq_clr = acc_now & req.write & (req.address == PERFSEL_OFS_IRQ_CLR);
  assign wr_irq_en = acc_now & req.write & (req.address == PERFSEL_OFS_IRQ_EN);

  // Waitrequest drops for one cycle, one cycle after a request appears.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((req.read | req.write) & wait_r);
    end
  end

  // Read data is latched as waitrequest drops; unmapped offsets read zero.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (req.read & wait_r) begin
      unique case (req.address)
        PERFSEL_OFS_CTRL: begin
          rdata_r <= ctrl_r;
        end
        PERFSEL_OFS_COUNT: begin
          rdata_r <= 32'(count_r);
        end
        PERFSEL_OFS_STATUS: begin
          rdata_r <= 32'(status_r);
        end
        PERFSEL_OFS_IRQ_EN: begin
          rdata_r <= 32'(irq_en_r);
        end
        default: begin
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Selection and enable; only code, mask and enable bits are kept.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= PERFSEL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= be_merge(ctrl_r, req.writedata, req.byteenable) & 32'h0001_FFFF;
    end
  end

  // The counter sum carries one extra bit to detect a wrap.
  assign count_sum = {1'b0, count_r} + (CNT_W+1)'(inc);

  // A software preset wins over an event in the same cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= CNT_W'(PERFSEL_COUNT_RST);
    end else if (wr_count) begin
      count_r <= CNT_W'(be_merge(32'(count_r), req.writedata, req.byteenable));
    end else if (count_en & sel_known) begin
      count_r <= count_sum[CNT_W-1:0];
    end
  end

  // Status events: counter wrap, and counting enabled on an unknown selection.
  assign st_set[PERFSEL_ST_WRAP] = ~wr_count & count_en & sel_known & count_sum[CNT_W];
  assign st_set[PERFSEL_ST_BADSEL] = count_en & ~sel_known;

  // Sticky status; a new event beats a clear in the same cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= '0;
    end else if (wr_irq_clr) begin
      status_r <= (status_r & ~req.writedata[PERFSEL_ST_W-1:0]) | st_set;
    end else begin
      status_r <= status_r | st_set;
    end
  end

  // Interrupt enable mask.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_r <= '0;
    end else if (wr_irq_en & req.byteenable[0]) begin
      irq_en_r <= req.writedata[PERFSEL_ST_W-1:0];
    end
  end

  // Registered interrupt keeps the output glitch free at one cycle of lag.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & irq_en_r);
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign irq = irq_r;

endmodule

// *** test/pes_assertions.sv ***
// Checker for the event-select counter: bus handshake, read values and interrupt fall.
// Assumes it is bound to perfsel_top and sees only that module's ports.
`timescale 1ns/100ps
module pes_chk
  import perfsel_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pipeline conditions and interrupt.
  input wire perfsel_cond_t cond,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Completed accesses, seen in the one cycle where waitrequest is low.
  wire logic rd_done = avs_read && !avs_waitrequest;
  wire logic wr_irq = avs_write && !avs_waitrequest &&
    (avs_address == PERFSEL_OFS_IRQ_CLR || avs_address == PERFSEL_OFS_IRQ_EN);
  wire logic mapped = avs_address inside {PERFSEL_OFS_CTRL, PERFSEL_OFS_COUNT,
    PERFSEL_OFS_STATUS, PERFSEL_OFS_IRQ_CLR, PERFSEL_OFS_IRQ_EN};

  // A fresh request waits exactly one cycle, then waitrequest returns high.
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_WAIT_ONE: assert property (s_req |=> s_ans)
    else $error("bus answer not one wait cycle");
  AST_IDLE_WAIT: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  AST_UNMAPPED_READ: assert property (rd_done && !mapped |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_CLR_READ: assert property (rd_done && avs_address == PERFSEL_OFS_IRQ_CLR
    |-> avs_readdata == 32'h0000_0000) else $error("clear register read not zero");
  AST_STATUS_RO: assert property (rd_done && avs_address == PERFSEL_OFS_STATUS
    |-> avs_readdata[31:2] == 30'h0000_0000) else $error("status spare bits set");
  AST_CTRL_UPPER: assert property (rd_done && avs_address == PERFSEL_OFS_CTRL
    |-> avs_readdata[31:17] == 15'h0000) else $error("control spare bits set");
  AST_READ_STABLE: assert property (!$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_irq, 1) || $past(wr_irq, 2))
    else $error("interrupt fell without clear or mask");
  AST_IRQ_HOLD: assert property (irq && !wr_irq && !$past(wr_irq) |=> irq)
    else $error("interrupt dropped by itself");
endmodule

bind perfsel_top pes_chk #(.CNT_W(CNT_W)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cond(cond), .irq(irq));

// *** test/pes_pipe_model.sv ***
// Pipeline condition source: replays one condition pattern for a set number of cycles.
// Assumes the bench requests each burst with a one-cycle start strobe.
`timescale 1ns/100ps
module pes_pipe_model
  import perfsel_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Burst request.
  input wire logic start,
  input wire perfsel_cond_t pat,
  input wire logic [7:0] len,
  // Conditions to the block.
  output perfsel_cond_t cond
);
  logic [7:0] left_r;
  perfsel_cond_t pat_r;

  // Load a burst; between bursts all lines fall low so no pulse lingers.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_r <= 8'h00;
      pat_r <= '0;
    end else if (start) begin
      left_r <= len;
      pat_r <= pat;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end

  // Pulses and levels alike stand for exactly len cycles.
  assign cond = (left_r != 8'h00) ? pat_r : '0;
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the event-select counter.
// Assumes the pipeline model drives cond and this bench is the bus master.
`timescale 1ns/100ps
module tb_top
  import perfsel_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic start = 1'b0;
  logic [7:0] len = 8'h00;
  perfsel_cond_t pat = '0;
  perfsel_cond_t cond;
  logic [31:0] d;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  // Core clock, 5 ns period.
  always #2.5 core_clk = ~core_clk;

  perfsel_top #(.CNT_W(32)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cond(cond), .irq(irq));
  pes_pipe_model u_pipe (.core_clk(core_clk), .rst_b(rst_b), .start(start), .pat(pat),
    .len(len), .cond(cond));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One access; held until waitrequest is sampled low, then one idle edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  // Condition patterns by index; several fields may be set at once.
  function automatic perfsel_cond_t cnd(input int k);
    perfsel_cond_t c;
    c = '0;
    case (k)
      0: c.seg_rename = 4'h8;
      1: c.seg_rename = 4'h7;
      2: c.seg_rename = 4'hF;
      3: c.retire_queue_full = 1'b1;
      4: c.issue_queue_full = 1'b1;
      5: c.fence_wait = 1'b1;
      6: c.float_cw_stall = 1'b1;
      7: c.branch_decoded = 1'b1;
      8: c.false_branch = 1'b1;
      9: c.frontend_resteer = 1'b1;
      10: c.upward_prefetch = 1'b1;
      11: c.downward_prefetch = 1'b1;
      12: c = ~(cnd(13) | cnd(15) | cnd(17));
      13: c.load_limit_hit = 1'b1;
      14: c.load_retired = 1'b1;
      15: c.store_limit_hit = 1'b1;
      16: c.store_committed = 1'b1;
      17: c.mispredict_detect = 1'b1;
      18: c.mispredict_drained = 1'b1;
      19: c = cnd(3) | cnd(6);
      default: c = '0;
    endcase
    return c;
  endfunction

  task automatic fire(input int k, input logic [7:0] n);
    pat <= cnd(k);
    len <= n;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic arm(input logic [7:0] ev, input logic [7:0] um);
    bus(1'b1, PERFSEL_OFS_COUNT, 32'h0000_0000);
    bus(1'b1, PERFSEL_OFS_CTRL, {15'h0000, 1'b1, um, ev});
  endtask

  task automatic fin(input logic [31:0] exp);
    bus(1'b1, PERFSEL_OFS_CTRL, 32'h0000_0000);
    bus(1'b0, PERFSEL_OFS_COUNT, 32'h0000_0000);
    chk(d, exp);
  endtask

  task automatic run_sel(input logic [7:0] ev, input logic [7:0] um, input int k,
      input logic [7:0] n, input logic [31:0] exp);
    arm(ev, um);
    fire(k, n);
    fin(exp);
  endtask

  // Span: start pulse, g+1 idle cycles, stop pulse; both pulse cycles count.
  task automatic span(input logic [7:0] um, input int ks, input int ke, input int g,
      input logic [31:0] exp);
    arm(PERFSEL_EV_RES_STALL, um);
    fire(ks, 8'h01);
    repeat (g) @(posedge core_clk);
    fire(ke, 8'h01);
    repeat (4) @(posedge core_clk);
    fin(exp);
  endtask

  task automatic t_regs();
    bus(1'b0, PERFSEL_OFS_CTRL, 32'h0000_0000);
    chk(d, PERFSEL_CTRL_RST);
    bus(1'b0, PERFSEL_OFS_COUNT, 32'h0000_0000);
    chk(d, PERFSEL_COUNT_RST);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0000_0000);
    chk(d, 32'h0000_0000);
    bus(1'b1, PERFSEL_OFS_CTRL, 32'hFFFF_FFFF);
    bus(1'b0, PERFSEL_OFS_CTRL, 32'h0000_0000);
    chk(d, 32'h0001_FFFF);
  endtask

  task automatic t_events();
    run_sel(8'hD5, 8'h08, 0, 8'h03, 32'h0000_0003);
    run_sel(8'hD5, 8'h08, 1, 8'h03, 32'h0000_0000);
    run_sel(8'hD5, 8'h0F, 2, 8'h02, 32'h0000_0008);
    run_sel(8'hD5, 8'h0F, 1, 8'h03, 32'h0000_0009);
    run_sel(8'hDC, 8'h01, 3, 8'h04, 32'h0000_0004);
    run_sel(8'hDC, 8'h01, 5, 8'h04, 32'h0000_0000);
    run_sel(8'hDC, 8'h02, 4, 8'h04, 32'h0000_0004);
    run_sel(8'hDC, 8'h04, 5, 8'h03, 32'h0000_0003);
    run_sel(8'hDC, 8'h08, 6, 8'h03, 32'h0000_0003);
    run_sel(8'hDC, 8'h1F, 19, 8'h03, 32'h0000_0003);
    run_sel(8'hE0, 8'h00, 7, 8'h05, 32'h0000_0005);
    run_sel(8'hE4, 8'h00, 8, 8'h02, 32'h0000_0002);
    run_sel(8'hE6, 8'h00, 9, 8'h03, 32'h0000_0003);
    run_sel(8'hF0, 8'h00, 10, 8'h04, 32'h0000_0004);
    run_sel(8'hF8, 8'h00, 11, 8'h02, 32'h0000_0002);
    run_sel(8'hDC, 8'h03, 12, 8'h03, 32'h0000_0000);
    run_sel(8'hE0, 8'h01, 7, 8'h03, 32'h0000_0000);
    span(8'h04, 13, 14, 5, 32'h0000_0008);
    span(8'h04, 15, 16, 2, 32'h0000_0005);
    span(8'h10, 17, 18, 6, 32'h0000_0009);
    span(8'h1F, 17, 18, 0, 32'h0000_0003);
  endtask

  // Wrap raises status and irq; masking holds status, clearing drops both.
  task automatic t_irq();
    bus(1'b1, PERFSEL_OFS_IRQ_CLR, 32'h0000_0003);
    bus(1'b1, PERFSEL_OFS_IRQ_EN, 32'h0000_0001);
    bus(1'b1, PERFSEL_OFS_COUNT, 32'hFFFF_FFFF);
    bus(1'b1, PERFSEL_OFS_CTRL, {15'h0000, 1'b1, PERFSEL_UM_NONE, PERFSEL_EV_BR_DECODED});
    fire(7, 8'h02);
    fin(32'h0000_0001);
    bus(1'b0, PERFSEL_OFS_STATUS, 32'h0000_0000);
    chk(d, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    bus(1'b1, PERFSEL_OFS_IRQ_EN, 32'h0000_0000);
    @(posedge core_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1'b1, PERFSEL_OFS_IRQ_EN, 32'h0000_0003);
    @(posedge core_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    bus(1'b1, PERFSEL_OFS_IRQ_CLR, 32'h0000_0001);
    @(posedge core_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    bus(1'b0, PERFSEL_OFS_IRQ_CLR, 32'h0000_0000);
    chk(d, 32'h0000_0000);
    run_sel(8'hDC, 8'h20, 3, 8'h02, 32'h0000_0000);
    bus(1'b0, PERFSEL_OFS_STATUS, 32'h0000_0000);
    chk(d, 32'h0000_0002);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
  endtask

  // Main sequence after a six-cycle reset.
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_events();
    t_irq();
    give_verdict();
  end

  // Watchdog: the whole run needs well under 3000 cycles.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
endmodule
